// [sdic_cfg.svh]
/*
 * constants of the step/direction input conditioner: register offsets, field positions,
 * reset values and timing figures.
 * assumes a 20 MHz clock and word-aligned Avalon-MM access.
 */
`ifndef SDIC_CFG_SVH
`define SDIC_CFG_SVH
// How it works
// - in closed loop step mode, status bit 13 sets when error exceeds window past timeout.
// - subtype 0: each clock pulse is one step, direction input picks rotation.
// - subtype 1: pulses on one input step clockwise, on the other counter-clockwise.
// - writing 0xfe to operating mode selects automatic identification.
// - in identification mode a travel starts only on a rising edge of control bit 4.
// - during identification status bit 10 shows whether an index pulse was seen.
// - status bit 12 sets once identification has completed.
// - inputs 1..3 have a special bit in 0..2; each input has a level bit at 15+n.
// - level bits show conditioned state regardless of special-function enable.
// - inputs are sampled once per millisecond; shorter pulses may be missed.
// - input 1 negative limit, 2 positive limit or direction, 3 home or clock.
// - differential select 1 folds six inputs into three pairs; 0 is single-ended.
// - enable bits 0..2 gate limit and home functions; interlock bit 3 stays clear; never level bits.
// - invert bit n-1 flips input n, but not the clock and direction functions.
// - a set force-enable bit substitutes the force value for the conditioned level, after inversion.
// - raw word shows sampled pin levels before inversion or forcing.
// - input 1 drives bit 0 as negative limit and its full result on bit 16.
// - with routing on, enable, invert and force settings have no effect.
// - turning routing on preloads the table from the enable and invert settings; force and pair settings are not carried over.
// - every accepted step pulse moves one step in the indicated direction.
// - step size per pulse is numerator over denominator, default 128.
// - with routing on, table entry n selects the source driven onto image bit n.
`define SDIC_A_IMAGE     4'h0
`define SDIC_A_SFMASK    4'h1
`define SDIC_A_POLMASK   4'h2
`define SDIC_A_OVREN     4'h3
`define SDIC_A_OVRVAL    4'h4
`define SDIC_A_RAW       4'h5
`define SDIC_A_PAIR      4'h6
`define SDIC_A_REMAPEN   4'h7
`define SDIC_A_SUBTYPE   4'h8
`define SDIC_A_OPMODE    4'h9
`define SDIC_A_CTRL      4'ha
`define SDIC_A_STATUS    4'hb
`define SDIC_A_STEPNUM   4'hc
`define SDIC_A_STEPDEN   4'hd
`define SDIC_A_POS       4'he
`define SDIC_A_ROUTE     4'hf
`define SDIC_LEVEL_LSB   16
`define SDIC_SF_NEG      0
`define SDIC_SF_POS      1
`define SDIC_SF_HOME     2
`define SDIC_SF_ILOCK    3
`define SDIC_CW_START    4
`define SDIC_ST_INDEXED  10
`define SDIC_ST_ALIGNED  12
`define SDIC_ST_FOLLOW   13
`define SDIC_OPMODE_AUTO 8'hfe
`define SDIC_OPMODE_STEP 8'hff
`define SDIC_SUB_PULSE   8'h00
`define SDIC_SUB_DUAL    8'h01
`define SDIC_STEPNUM_RST 32'h0000_0080
`define SDIC_STEPDEN_RST 32'h0000_0001
`define SDIC_CLK_HZ      20000000
`define SDIC_SAMPLE_US   1000
`define SDIC_SAMPLE_CYC  ((`SDIC_CLK_HZ / 1000000) * `SDIC_SAMPLE_US)
`define SDIC_SRC_ONE     8'h80
`define SDIC_SRC_PIN_LO  7'h01
`define SDIC_SRC_PIN_HI  7'h10
`define SDIC_SRC_ENC_LO  7'h44
`define SDIC_SRC_ENC_HI  7'h47
`endif

// [sdic_pkg.sv]
/*
 * types of the step/direction input conditioner.
 * assumes sdic_cfg.svh supplies the numeric constants.
 */
`default_nettype none
package sdic_pkg;
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } sdic_req_t;

    typedef struct packed {
        logic        fe_window_exceeded;
        logic        fe_timeout_elapsed;
        logic        closed_loop;
        logic        index_seen;
        logic        setup_done;
    } sdic_motion_t;

    typedef enum logic [1:0] {
        SDIC_ID_IDLE = 2'b00,
        SDIC_ID_RUN  = 2'b01,
        SDIC_ID_DONE = 2'b10
    } sdic_id_state_t;
endpackage
`default_nettype wire

// [sdic_top.sv]
/*
 * step/direction input conditioner: samples six pins every millisecond, conditions them into
 * the input image, decodes step pulses into a signed position, tracks auto setup status.
 * assumes pins synchronous to clk_i and an Avalon-MM master honouring waitrequest.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sdic_cfg.svh"
module sdic_top #(
    parameter int N_IN       = 6,
    parameter int SAMPLE_CYC = `SDIC_SAMPLE_CYC
) (
    input  wire logic                clk_i,          // 20 MHz
    input  wire logic                resetn_i,       // async, active low
    input  wire sdic_pkg::sdic_req_t av_req_i,       // avalon request
    output var  logic [31:0]         av_readdata_o,  // read data
    output logic                     av_waitrequest_o, // low when answer stands
    input  wire logic [N_IN-1:0]     pin_i,          // input pins
    input  wire logic [3:0]          enc_i,          // encoder a, b, index, usb power
    input  wire sdic_pkg::sdic_motion_t motion_i,    // motion core status
    output var  logic [31:0]         input_image_o,  // conditioned image
    output var  logic [31:0]         step_pos_o,     // accumulated step position
    output var  logic                travel_start_o, // travel command pulse
    output var  logic                auto_mode_o     // identification mode active
);
    logic [31:0] sfmask_r, polmask_r, ovren_r, ovrval_r, raw_r, image_r;
    logic [31:0] stepnum_r, stepden_r, pos_r, ctrl_r;
    logic [7:0]  pair_r, remap_r, subtype_r, opmode_r, route_sel_r;
    logic [7:0]  route_r [0:31];
    logic [31:0] readdata_r;
    logic        ack_r, ctrl4_q, id_index_r, id_done_r, fe_r, tick;
    logic [$clog2(SAMPLE_CYC)-1:0] tick_cnt_r;
    logic [N_IN-1:0] cond, lvl_in, lvl_prev_r;
    logic [31:0] img_nxt;
    sdic_pkg::sdic_id_state_t id_state_r;
    wire logic wr = av_req_i.write & ack_r;
    wire logic rd = av_req_i.read & ~ack_r;
    wire logic [3:0] adr = av_req_i.address;

    // one cycle of wait per access; a write lands only at the edge that completes the transfer
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ack_r <= 1'b0;
        else
            ack_r <= (av_req_i.read | av_req_i.write) & ~ack_r;
    end
    assign av_waitrequest_o = ~ack_r;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            tick_cnt_r <= '0;
        else if (tick)
            tick_cnt_r <= '0;
        else
            tick_cnt_r <= tick_cnt_r + 1'b1;
    end
    assign tick = (tick_cnt_r == ($clog2(SAMPLE_CYC))'(SAMPLE_CYC - 1));

    // pair mode: pin 2k+1 minus pin 2k; a differential pair reads high when its plus leg is above
    always_comb
    begin
        for (int i = 0; i < N_IN; i++)
            cond[i] = 1'b0;
        for (int i = 0; i < N_IN; i++)
        begin
            if (pair_r[0])
            begin
                if (i < N_IN / 2)
                    cond[i] = raw_r[2*i+1] & ~raw_r[2*i];
            end
            else
                cond[i] = raw_r[i] ^ polmask_r[i];
            if (pair_r[0] && i < N_IN / 2)
                cond[i] = cond[i] ^ polmask_r[i];
            if (ovren_r[i])
                cond[i] = ovrval_r[i];
        end
    end

    function automatic logic route_src(input logic [7:0] sel, input logic [31:0] raw, input logic [3:0] enc);
        logic v;
        v = 1'b0;
        if (sel[6:0] >= `SDIC_SRC_PIN_LO && sel[6:0] <= `SDIC_SRC_PIN_HI)
            v = raw[sel[4:0] - 5'h01];
        else if (sel[6:0] >= `SDIC_SRC_ENC_LO && sel[6:0] <= `SDIC_SRC_ENC_HI)
            v = enc[sel[1:0]];
        return v ^ sel[7];
    endfunction

    always_comb
    begin
        img_nxt = 32'h0000_0000;
        if (remap_r[0])
        begin
            for (int b = 0; b < 32; b++)
                img_nxt[b] = route_src(route_r[b], raw_r, enc_i);
        end
        else
        begin
            for (int i = 0; i < N_IN; i++)
                img_nxt[`SDIC_LEVEL_LSB + i] = cond[i];
            img_nxt[`SDIC_SF_NEG]   = cond[0] & sfmask_r[`SDIC_SF_NEG];
            img_nxt[`SDIC_SF_POS]   = cond[1] & sfmask_r[`SDIC_SF_POS];
            img_nxt[`SDIC_SF_HOME]  = cond[2] & sfmask_r[`SDIC_SF_HOME];
            img_nxt[`SDIC_SF_ILOCK] = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            raw_r   <= 32'h0000_0000;
            image_r <= 32'h0000_0000;
        end
        else if (tick)
        begin
            raw_r   <= {{(32-N_IN){1'b0}}, pin_i};
            image_r <= img_nxt;
        end
    end
    assign input_image_o = image_r;

    // step decode on raw levels: inversion never touches clock and direction
    assign lvl_in = raw_r[N_IN-1:0];
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            lvl_prev_r <= '0;
        else if (tick)
            lvl_prev_r <= lvl_in;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pos_r <= 32'h0000_0000;
        else if (tick && opmode_r == `SDIC_OPMODE_STEP && stepden_r != 32'h0000_0000)
        begin
            if (subtype_r == `SDIC_SUB_PULSE && lvl_in[2] && !lvl_prev_r[2])
                pos_r <= lvl_in[1] ? pos_r - stepnum_r / stepden_r : pos_r + stepnum_r / stepden_r;
            else if (subtype_r == `SDIC_SUB_DUAL && lvl_in[2] && !lvl_prev_r[2])
                pos_r <= pos_r + stepnum_r / stepden_r;
            else if (subtype_r == `SDIC_SUB_DUAL && lvl_in[1] && !lvl_prev_r[1])
                pos_r <= pos_r - stepnum_r / stepden_r;
        end
    end
    assign step_pos_o = pos_r;

    // identification: start on rising control bit 4 only
    assign auto_mode_o = (opmode_r == `SDIC_OPMODE_AUTO);
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ctrl4_q <= 1'b0;
        else
            ctrl4_q <= ctrl_r[`SDIC_CW_START];
    end
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            travel_start_o <= 1'b0;
        else
            travel_start_o <= auto_mode_o & ctrl_r[`SDIC_CW_START] & ~ctrl4_q;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            id_state_r <= sdic_pkg::SDIC_ID_IDLE;
            id_index_r <= 1'b0;
            id_done_r  <= 1'b0;
        end
        else
        begin
            case (id_state_r)
                sdic_pkg::SDIC_ID_IDLE:
                    if (travel_start_o)
                    begin
                        id_state_r <= sdic_pkg::SDIC_ID_RUN;
                        id_index_r <= 1'b0;
                        id_done_r  <= 1'b0;
                    end
                sdic_pkg::SDIC_ID_RUN:
                begin
                    if (motion_i.index_seen)
                        id_index_r <= 1'b1;
                    if (motion_i.setup_done)
                    begin
                        id_done_r  <= 1'b1;
                        id_state_r <= sdic_pkg::SDIC_ID_DONE;
                    end
                end
                default:
                    if (travel_start_o)
                        id_state_r <= sdic_pkg::SDIC_ID_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            fe_r <= 1'b0;
        else
            fe_r <= motion_i.closed_loop & (opmode_r == `SDIC_OPMODE_STEP)
                    & motion_i.fe_window_exceeded & motion_i.fe_timeout_elapsed;
    end

    // register writes
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sfmask_r <= 32'h0000_0000;
            polmask_r <= 32'h0000_0000;
            ovren_r <= 32'h0000_0000;
            ovrval_r <= 32'h0000_0000;
            pair_r <= 8'h00;
            remap_r <= 8'h00;
            subtype_r <= `SDIC_SUB_PULSE;
            opmode_r <= 8'h00;
            ctrl_r <= 32'h0000_0000;
            stepnum_r <= `SDIC_STEPNUM_RST;
            stepden_r <= `SDIC_STEPDEN_RST;
            route_sel_r <= 8'h00;
        end
        else if (wr)
        begin
            if (adr == `SDIC_A_SFMASK)
                sfmask_r <= av_req_i.writedata;
            else if (adr == `SDIC_A_POLMASK)
                polmask_r <= av_req_i.writedata;
            else if (adr == `SDIC_A_OVREN)
                ovren_r <= av_req_i.writedata;
            else if (adr == `SDIC_A_OVRVAL)
                ovrval_r <= av_req_i.writedata;
            else if (adr == `SDIC_A_PAIR)
                pair_r <= av_req_i.writedata[7:0];
            else if (adr == `SDIC_A_REMAPEN)
                remap_r <= av_req_i.writedata[7:0];
            else if (adr == `SDIC_A_SUBTYPE)
                subtype_r <= av_req_i.writedata[7:0];
            else if (adr == `SDIC_A_OPMODE)
                opmode_r <= av_req_i.writedata[7:0];
            else if (adr == `SDIC_A_CTRL)
                ctrl_r <= av_req_i.writedata;
            else if (adr == `SDIC_A_STEPNUM)
                stepnum_r <= av_req_i.writedata;
            else if (adr == `SDIC_A_STEPDEN)
                stepden_r <= av_req_i.writedata;
            else if (adr == `SDIC_A_ROUTE)
                route_sel_r <= av_req_i.writedata[7:0];
        end
    end

    // route table: write {entry, source} at ROUTE data; enabling routing preloads the mapping set by the enable and invert masks
    always_ff @(posedge clk_i)
    begin
        for (int b = 0; b < 32; b++)
        begin
            if (wr && adr == `SDIC_A_REMAPEN && av_req_i.writedata[0] && !remap_r[0])
            begin
                if (b >= `SDIC_LEVEL_LSB && b < `SDIC_LEVEL_LSB + N_IN)
                    route_r[b] <= polmask_r[b-`SDIC_LEVEL_LSB] ? 8'(`SDIC_SRC_ONE + b - `SDIC_LEVEL_LSB + 1)
                                                              : 8'(b - `SDIC_LEVEL_LSB + 1);
                else if (b <= `SDIC_SF_HOME && sfmask_r[b])
                    route_r[b] <= polmask_r[b] ? 8'(`SDIC_SRC_ONE + b + 1) : 8'(b + 1);
                else
                    route_r[b] <= 8'h00;
            end
            else if (wr && adr == `SDIC_A_ROUTE && av_req_i.writedata[12:8] == 5'(b))
                route_r[b] <= av_req_i.writedata[7:0];
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            readdata_r <= 32'h0000_0000;
        else if (rd)
        begin
            if (adr == `SDIC_A_IMAGE)
                readdata_r <= image_r;
            else if (adr == `SDIC_A_SFMASK)
                readdata_r <= sfmask_r;
            else if (adr == `SDIC_A_POLMASK)
                readdata_r <= polmask_r;
            else if (adr == `SDIC_A_OVREN)
                readdata_r <= ovren_r;
            else if (adr == `SDIC_A_OVRVAL)
                readdata_r <= ovrval_r;
            else if (adr == `SDIC_A_RAW)
                readdata_r <= raw_r;
            else if (adr == `SDIC_A_PAIR)
                readdata_r <= {24'h000000, pair_r};
            else if (adr == `SDIC_A_REMAPEN)
                readdata_r <= {24'h000000, remap_r};
            else if (adr == `SDIC_A_SUBTYPE)
                readdata_r <= {24'h000000, subtype_r};
            else if (adr == `SDIC_A_OPMODE)
                readdata_r <= {24'h000000, opmode_r};
            else if (adr == `SDIC_A_CTRL)
                readdata_r <= ctrl_r;
            else if (adr == `SDIC_A_STATUS)
                readdata_r <= (32'(fe_r) << `SDIC_ST_FOLLOW) | (32'(id_done_r) << `SDIC_ST_ALIGNED)
                              | (32'(id_index_r & auto_mode_o) << `SDIC_ST_INDEXED);
            else if (adr == `SDIC_A_STEPNUM)
                readdata_r <= stepnum_r;
            else if (adr == `SDIC_A_STEPDEN)
                readdata_r <= stepden_r;
            else if (adr == `SDIC_A_POS)
                readdata_r <= pos_r;
            else
                readdata_r <= 32'h0000_0000;
        end
    end
    assign av_readdata_o = readdata_r;

    sequence rise4_s;
        auto_mode_o && ctrl_r[`SDIC_CW_START] && !ctrl4_q;
    endsequence
    travel_edge_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rise4_s |=> travel_start_o) else $error("travel start missing");
    travel_level_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        travel_start_o |-> $past(ctrl_r[`SDIC_CW_START]) && !$past(ctrl4_q) && $past(auto_mode_o))
        else $error("travel bad");
    unused_bits_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tick && !remap_r[0] |=> image_r[15:4] == 12'h000 && !image_r[`SDIC_SF_ILOCK]) else $error("spare bits set");
    level_only_tick_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !$past(tick) |-> $stable(raw_r)) else $error("raw changed off tick");
    sf_gated_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tick && !remap_r[0] && !sfmask_r[0] |=> !image_r[0]) else $error("disabled function active");
    level_bit_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tick && !remap_r[0] |=> image_r[16] == $past(cond[0])) else $error("level bit wrong");
    force_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ovren_r[0] |-> cond[0] == ovrval_r[0]) else $error("force not applied");
    wait_one_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (av_req_i.read || av_req_i.write) && av_waitrequest_o |=> !av_waitrequest_o) else $error("slow answer");
endmodule
`default_nettype wire

// [sdic_pin_model.sv]
/*
 * far-side model: limit/home switches and a step/direction positioning controller on the six pins.
 * assumes the bench calls its tasks and that clk_i is the block clock.
 */
`timescale 1ns/10ps
`default_nettype none
module sdic_pin_model #(
    parameter int HOLD     = 44,
    parameter int DIR_WAIT = 700
) (
    input  wire logic       clk_i, // block clock
    output var  logic [5:0] pin_o  // input pins of the block
);
    initial pin_o = 6'h00;

    task automatic set_pins(input logic [5:0] v);
        @(posedge clk_i);
        pin_o <= v;
    endtask

    // line 2 is clock, line 1 is direction or ccw; each level outlasts a sample tick
    task automatic step(input int line, input logic dir);
        if (line == 2 && pin_o[1] !== dir)
        begin
            @(posedge clk_i);
            pin_o[1] <= dir;
            repeat (DIR_WAIT) @(posedge clk_i);
        end
        @(posedge clk_i);
        pin_o[line] <= 1'b1;
        repeat (HOLD) @(posedge clk_i);
        pin_o[line] <= 1'b0;
        repeat (HOLD) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// [sdic_top_tb.sv]
/*
 * self-checking bench of sdic_top: avalon register tasks and directed scenarios.
 * assumes sdic_pin_model on the pins and a sample tick shortened to SC cycles.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sdic_cfg.svh"
module sdic_top_tb;
    localparam int SC = 20;
    logic                   clk_i = 1'b0;
    logic                   resetn_i = 1'b0;
    sdic_pkg::sdic_req_t    req = '0;
    sdic_pkg::sdic_motion_t mot = '0;
    logic [3:0]             enc = 4'h0;
    logic [5:0]             pins;
    logic [31:0]            rdata, img, pos, rv, p0;
    logic                   wreq, travel, auto_m;
    int                     err_total = 0;
    int                     samples_checked = 0;
    int                     trav_cnt = 0;

    always #25 clk_i = ~clk_i;

    sdic_top #(.SAMPLE_CYC(SC)) dut (
        .clk_i            (clk_i),
        .resetn_i         (resetn_i),
        .av_req_i         (req),
        .av_readdata_o    (rdata),
        .av_waitrequest_o (wreq),
        .pin_i            (pins),
        .enc_i            (enc),
        .motion_i         (mot),
        .input_image_o    (img),
        .step_pos_o       (pos),
        .travel_start_o   (travel),
        .auto_mode_o      (auto_m)
    );

    sdic_pin_model #(.HOLD(2 * SC + 4)) u_sw (
        .clk_i (clk_i),
        .pin_o (pins)
    );

    always @(posedge clk_i)
        if (travel === 1'b1)
            trav_cnt++;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{read: !wr, write: wr, address: a, writedata: d};
        @(posedge clk_i);
        while (wreq !== 1'b0 && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        q = rdata;
        req <= '0;
        if (n >= 40)
            err_total++;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, rv);
        chk(rv, exp);
    endtask

    task automatic settle;
        repeat (3 * SC + 4) @(posedge clk_i);
    endtask

    initial
    begin
        repeat (40000) @(posedge clk_i);
        err_total++;
        report_and_stop;
    end

    initial
    begin
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd_chk(`SDIC_A_SUBTYPE, 32'h0);
        rd_chk(`SDIC_A_STEPNUM, 32'h80);
        rd_chk(`SDIC_A_STEPDEN, 32'h1);
        // conditioning: in2 inverted, in5 forced high
        u_sw.set_pins(6'h05);
        wr(`SDIC_A_SFMASK, 32'h7);
        wr(`SDIC_A_POLMASK, 32'h2);
        wr(`SDIC_A_OVREN, 32'h10);
        wr(`SDIC_A_OVRVAL, 32'h10);
        wr(`SDIC_A_RAW, 32'hff);
        settle;
        rd_chk(`SDIC_A_RAW, 32'h5);
        rd_chk(`SDIC_A_IMAGE, 32'h0017_0007);
        chk(img, 32'h0017_0007);
        wr(`SDIC_A_SFMASK, 32'h0);
        settle;
        rd_chk(`SDIC_A_IMAGE, 32'h0017_0000);
        // differential pairs
        wr(`SDIC_A_POLMASK, 32'h0);
        wr(`SDIC_A_OVREN, 32'h0);
        wr(`SDIC_A_PAIR, 32'h1);
        u_sw.set_pins(6'h26);
        settle;
        bus(1'b0, `SDIC_A_IMAGE, 32'h0, rv);
        chk({29'h0, rv[18:16]}, 32'h5);
        wr(`SDIC_A_PAIR, 32'h0);
        // auto identification
        wr(`SDIC_A_OPMODE, {24'h0, `SDIC_OPMODE_AUTO});
        repeat (2) @(posedge clk_i);
        chk({31'h0, auto_m}, 32'h1);
        trav_cnt = 0;
        wr(`SDIC_A_CTRL, 32'h10);
        wr(`SDIC_A_CTRL, 32'h10);
        repeat (4) @(posedge clk_i);
        chk(32'(trav_cnt), 32'h1);
        wr(`SDIC_A_CTRL, 32'h0);
        wr(`SDIC_A_CTRL, 32'h10);
        repeat (4) @(posedge clk_i);
        chk(32'(trav_cnt), 32'h2);
        rd_chk(`SDIC_A_STATUS, 32'h0);
        mot <= 5'h03;
        bus(1'b0, `SDIC_A_STATUS, 32'h0, rv);
        chk(rv & 32'h1400, 32'h1400);
        // step input, inversion must not touch clock or direction
        wr(`SDIC_A_OPMODE, {24'h0, `SDIC_OPMODE_STEP});
        wr(`SDIC_A_POLMASK, 32'h3f);
        u_sw.set_pins(6'h00);
        settle;
        bus(1'b0, `SDIC_A_POS, 32'h0, p0);
        for (int i = 0; i < 3; i++)
            u_sw.step(2, 1'b0);
        for (int i = 0; i < 2; i++)
            u_sw.step(2, 1'b1);
        settle;
        rd_chk(`SDIC_A_POS, p0 + 32'h80);
        u_sw.set_pins(6'h00);
        wr(`SDIC_A_SUBTYPE, 32'h1);
        wr(`SDIC_A_STEPNUM, 32'h200);
        wr(`SDIC_A_STEPDEN, 32'h2);
        settle;
        for (int i = 0; i < 2; i++)
            u_sw.step(2, 1'b0);
        u_sw.step(1, 1'b0);
        settle;
        rd_chk(`SDIC_A_POS, p0 + 32'h180);
        chk(pos, p0 + 32'h180);
        mot <= 5'h1c;
        bus(1'b0, `SDIC_A_STATUS, 32'h0, rv);
        chk(rv & 32'h2000, 32'h2000);
        mot <= 5'h14;
        bus(1'b0, `SDIC_A_STATUS, 32'h0, rv);
        chk(rv & 32'h2000, 32'h0);
        // routing
        wr(`SDIC_A_OPMODE, 32'h0);
        wr(`SDIC_A_SUBTYPE, 32'h0);
        wr(`SDIC_A_POLMASK, 32'h0);
        wr(`SDIC_A_SFMASK, 32'h7);
        u_sw.set_pins(6'h05);
        enc <= 4'h4;
        settle;
        rd_chk(`SDIC_A_IMAGE, 32'h0005_0005);
        wr(`SDIC_A_REMAPEN, 32'h1);
        wr(`SDIC_A_POLMASK, 32'h3f);
        wr(`SDIC_A_OVREN, 32'h3f);
        settle;
        rd_chk(`SDIC_A_IMAGE, 32'h0005_0005);
        wr(`SDIC_A_ROUTE, 32'h1180);
        wr(`SDIC_A_ROUTE, 32'h1200);
        wr(`SDIC_A_ROUTE, 32'h0146);
        settle;
        rd_chk(`SDIC_A_IMAGE, 32'h0003_0007);
        rd_chk(`SDIC_A_ROUTE, 32'h0);
        report_and_stop;
    end
endmodule
`default_nettype wire
